// [core/relay_device.sv]
// relay end: control variables, events, status, time, faults
`timescale 1ns/1ps
`default_nettype none
`include "relay_access_map.svh"
module relay_device #(
   parameter logic [15:0] TYPE_CODE = 16'h00A5 // arbitrary value
) (
   input wire logic clk,
   input wire logic rst,
   relay_access_if.device link,
   input wire logic event_valid,
   input wire logic [7:0] event_channel,
   input wire logic [7:0] event_code,
   input wire logic auto_reset_seen,
   input wire logic [15:0] fault_flags,
   input wire logic adc_tick,
   input wire logic setting_we,
   input wire logic [15:0] setting_val,
   input wire logic [15:0] setting_max,
   output logic relay_release,
   output logic record_clear,
   output logic supervision_input,
   output logic internal_fault_indicator,
   output logic supervision_relay,
   output logic eeprom_format,
   output logic power_cycle,
   output logic [7:0] fault_code,
   output logic [15:0] setting_q,
   output logic [7:0] bus_node_address,
   output logic rate_is_9600
);
   localparam int DEPTH = 4;
   typedef struct packed {
      relay_access_pkg::dev_state_t st;
      logic ack, ok;
      logic [15:0] rdata;
      relay_access_pkg::event_t evt, last_evt;
      logic [7:0] m0, m1, m2, m3;
      logic [9:0] m4;
      logic [15:0] pw;
      logic open;
      logic [7:0] addr;
      logic r96;
      logic relay_rel, rec_clr, sup_in, ifi, sup_rel, fmt, pcyc;
      logic [7:0] fcode;
      logic [7:0] fdelay;
      logic [15:0] adc_cnt;
      logic ovf, autorst;
      logic [15:0] tms;
      logic [16:0] div;
      logic [15:0] setting;
      logic [DEPTH*32-1:0] fifo;
      logic [2:0] cnt;
   } dstate_t;
   dstate_t s_q, s_d;
   function automatic logic [7:0] fault_encode(input logic [15:0] f);
      logic [7:0] c;
      c = 8'h00;
      if (f[0]) c = `FAULT_TRIP_PATH;
      if (f[1]) c = `FAULT_ROM;
      if (f[2]) c = `FAULT_RAM;
      if (f[3]) c = `FAULT_EE_BLK1;
      if (f[4]) c = `FAULT_EE_BLK2;
      if (f[3] && f[4]) c = `FAULT_EE_BOTH;
      if (f[5]) c = `FAULT_EE_CSUM;
      if (f[6]) c = `FAULT_EE_KEY;
      if (f[7]) c = `FAULT_REF_LOW_X1;
      if (f[8]) c = `FAULT_REF_LOW_X5;
      if (f[9]) c = `FAULT_REF_LOW_X25;
      if (f[10]) c = `FAULT_REF_HIGH_X1;
      if (f[11]) c = `FAULT_REF_HIGH_X5;
      if (f[12]) c = `FAULT_REF_HIGH_X25;
      if (f[13]) c = `FAULT_EF_FILTER;
      return c;
   endfunction
   always_comb begin
      logic is_wr, is_act;
      logic [7:0] fc;
      s_d = s_q;
      is_wr = 1'b0;
      is_act = 1'b0;
      fc = 8'h00;
      s_d.ack = 1'b0;
      s_d.relay_rel = 1'b0;
      s_d.rec_clr = 1'b0;
      s_d.fmt = 1'b0;
      s_d.pcyc = 1'b0;
      s_d.sup_in = 1'b0;
      // millisecond clock, wraps below 60 s
      if (s_q.div == `MS_CYCLES - 17'd1) begin
         s_d.div = 17'd0;
         s_d.tms = (s_q.tms == `TIME_WRAP) ? 16'h0000 : s_q.tms + 16'h0001;
      end else begin
         s_d.div = s_q.div + 17'd1;
      end
      // converter watchdog
      if (adc_tick) begin
         s_d.adc_cnt = 16'h0000;
      end else if (s_q.adc_cnt != `ADC_TIMEOUT_CYCLES) begin
         s_d.adc_cnt = s_q.adc_cnt + 16'h0001;
      end
      fc = fault_encode(fault_flags);
      if (s_q.adc_cnt == `ADC_TIMEOUT_CYCLES) fc = `FAULT_ADC_STALL;
      s_d.fcode = fc;
      if (fc != 8'h00) begin
         if (s_q.fdelay != `FAULT_DELAY_CYCLES) s_d.fdelay = s_q.fdelay + 8'h01;
      end else begin
         s_d.fdelay = 8'h00;
      end
      s_d.sup_rel = (s_q.fdelay == `FAULT_DELAY_CYCLES);
      // local setting entry, also range-checked
      if (setting_we && setting_val <= setting_max) s_d.setting = setting_val;
      if (auto_reset_seen) s_d.autorst = 1'b1;
      case (s_q.st)
         relay_access_pkg::ST_IDLE: begin
            if (link.req) s_d.st = relay_access_pkg::ST_EXEC;
         end
         relay_access_pkg::ST_EXEC: begin
            s_d.ok = 1'b1;
            s_d.rdata = 16'h0000;
            is_wr = (link.cmd == relay_access_pkg::CMD_WRITE);
            is_act = (link.wdata == `ACTION_VALUE);
            case (link.cmd)
               relay_access_pkg::CMD_EVENT_READ: begin
                  if (s_q.cnt != 3'd0) begin
                     s_d.evt = s_q.fifo[31:0];
                     s_d.last_evt = s_q.fifo[31:0];
                     s_d.fifo = s_q.fifo >> 32;
                     s_d.cnt = s_q.cnt - 3'd1;
                  end else begin
                     s_d.ok = 1'b0;
                  end
               end
               relay_access_pkg::CMD_EVENT_REREAD: s_d.evt = s_q.last_evt;
               relay_access_pkg::CMD_READ, relay_access_pkg::CMD_WRITE: begin
                  case (link.var_id)
                     `VAR_SELF_HOLD_RESET: begin
                        if (is_wr && is_act) s_d.relay_rel = 1'b1;
                     end
                     `VAR_RELAY_RECORD_RESET: begin
                        if (is_wr && is_act) begin
                           s_d.relay_rel = 1'b1;
                           s_d.rec_clr = 1'b1;
                           s_d.cnt = 3'd0;
                        end
                     end
                     `VAR_MASK_STARTUP, `VAR_MASK_OVERCUR, `VAR_MASK_EARTH, `VAR_MASK_UNDERLOAD: begin
                        if (is_wr && link.wdata <= `MASK8_MAX) begin
                           if (link.var_id == `VAR_MASK_STARTUP) s_d.m0 = link.wdata[7:0];
                           if (link.var_id == `VAR_MASK_OVERCUR) s_d.m1 = link.wdata[7:0];
                           if (link.var_id == `VAR_MASK_EARTH) s_d.m2 = link.wdata[7:0];
                           if (link.var_id == `VAR_MASK_UNDERLOAD) s_d.m3 = link.wdata[7:0];
                        end else if (is_wr) begin
                           s_d.ok = 1'b0;
                        end
                        case (link.var_id)
                           `VAR_MASK_STARTUP: s_d.rdata = {8'h00, s_q.m0};
                           `VAR_MASK_OVERCUR: s_d.rdata = {8'h00, s_q.m1};
                           `VAR_MASK_EARTH: s_d.rdata = {8'h00, s_q.m2};
                           default: s_d.rdata = {8'h00, s_q.m3};
                        endcase
                     end
                     `VAR_MASK_OUTPUT: begin
                        if (is_wr && link.wdata <= `MASK10_MAX) s_d.m4 = link.wdata[9:0];
                        else if (is_wr) s_d.ok = 1'b0;
                        s_d.rdata = {6'h00, s_q.m4};
                     end
                     `VAR_PASSWORD_OPEN: begin
                        if (is_wr && link.wdata == s_q.pw) s_d.open = 1'b1;
                        else s_d.ok = 1'b0;
                     end
                     `VAR_PASSWORD_CHANGE: begin
                        if (is_wr && s_q.open && link.wdata == `PASSWORD_CLOSE) s_d.open = 1'b0;
                        else if (is_wr && s_q.open && link.wdata <= `PASSWORD_MAX) s_d.pw = link.wdata;
                        else s_d.ok = 1'b0;
                     end
                     `VAR_SUPERVISION_TEST: begin
                        if (is_wr && is_act) begin
                           s_d.sup_in = 1'b1;
                           s_d.ifi = 1'b1;
                        end
                     end
                     `VAR_FACTORY_FORMAT: begin
                        if (is_wr && s_q.open && link.wdata == `FORMAT_VALUE) begin
                           s_d.fmt = 1'b1;
                           s_d.pcyc = 1'b1;
                        end else if (is_wr) begin
                           s_d.ok = 1'b0;
                        end
                     end
                     `VAR_FAULT_CODE: s_d.rdata = {8'h00, s_q.fcode};
                     `VAR_NODE_ADDRESS: begin
                        if (is_wr && link.wdata >= `ADDR_MIN && link.wdata <= `ADDR_MAX) begin
                           s_d.addr = link.wdata[7:0];
                        end else if (is_wr) begin
                           s_d.ok = 1'b0;
                        end
                        s_d.rdata = {8'h00, s_q.addr};
                     end
                     `VAR_RATE_SELECT: begin
                        if (is_wr && link.wdata == `RATE_W_4K8) s_d.r96 = 1'b0;
                        else if (is_wr && link.wdata == `RATE_W_9K6) s_d.r96 = 1'b1;
                        else if (is_wr) s_d.ok = 1'b0;
                        s_d.rdata = s_q.r96 ? `RATE_9600 : `RATE_4800;
                     end
                     `VAR_STATUS: begin
                        if (is_wr && link.wdata == 16'h0000) begin
                           s_d.ovf = 1'b0;
                           s_d.autorst = auto_reset_seen;
                        end
                        s_d.rdata = {14'h0000, s_q.ovf, s_q.autorst};
                     end
                     `VAR_TIME: begin
                        if (is_wr && link.wdata <= `TIME_WRAP) s_d.tms = link.wdata;
                        s_d.rdata = s_q.tms;
                     end
                     `VAR_TYPE: s_d.rdata = TYPE_CODE;
                     default: begin
                        // protection setting, gated and range-checked
                        if (is_wr && s_q.open && link.wdata <= setting_max) s_d.setting = link.wdata;
                        else if (is_wr) s_d.ok = 1'b0;
                        s_d.rdata = s_q.setting;
                     end
                  endcase
               end
               default: s_d.ok = 1'b0;
            endcase
            s_d.ack = 1'b1;
            s_d.st = relay_access_pkg::ST_DONE;
         end
         relay_access_pkg::ST_DONE: s_d.st = relay_access_pkg::ST_IDLE;
         default: s_d.st = relay_access_pkg::ST_IDLE;
      endcase
      // event capture after reads so an arriving event is kept unless the queue stays full (then ovf is set)
      if (event_valid) begin
         if (s_d.cnt == 3'(DEPTH)) begin
            s_d.ovf = 1'b1;
         end else begin
            s_d.fifo[s_d.cnt*32 +: 32] = {s_q.tms, event_channel, event_code};
            s_d.cnt = s_d.cnt + 3'd1;
         end
      end
      if (fc != 8'h00 && s_q.fdelay == `FAULT_DELAY_CYCLES) s_d.ifi = 1'b1;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.st <= relay_access_pkg::ST_IDLE;
         s_q.pw <= `PASSWORD_RESET;
         s_q.addr <= `ADDR_RESET;
      end else begin
         s_q <= s_d;
      end
   end
   assign link.ack = s_q.ack;
   assign link.ok = s_q.ok;
   assign link.rdata = s_q.rdata;
   assign link.evt = s_q.evt;
   assign relay_release = s_q.relay_rel;
   assign record_clear = s_q.rec_clr;
   assign supervision_input = s_q.sup_in;
   assign internal_fault_indicator = s_q.ifi;
   assign supervision_relay = s_q.sup_rel;
   assign eeprom_format = s_q.fmt;
   assign power_cycle = s_q.pcyc;
   assign fault_code = s_q.fcode;
   assign setting_q = s_q.setting;
   assign bus_node_address = s_q.addr;
   assign rate_is_9600 = s_q.r96;
endmodule
`default_nettype wire

// [core/relay_access_map.svh]
// constants for the remote parameter access block
`ifndef RELAY_ACCESS_MAP_SVH
`define RELAY_ACCESS_MAP_SVH
`define VAR_SELF_HOLD_RESET 8'h65
`define VAR_RELAY_RECORD_RESET 8'h66
`define VAR_MASK_STARTUP 8'h9B
`define VAR_MASK_OVERCUR 8'h9C
`define VAR_MASK_EARTH 8'h9D
`define VAR_MASK_UNDERLOAD 8'h9E
`define VAR_MASK_OUTPUT 8'h9F
`define VAR_PASSWORD_OPEN 8'hA0
`define VAR_PASSWORD_CHANGE 8'hA1
`define VAR_SUPERVISION_TEST 8'hA5
`define VAR_FACTORY_FORMAT 8'hA7
`define VAR_FAULT_CODE 8'hA9
`define VAR_NODE_ADDRESS 8'hC8
`define VAR_RATE_SELECT 8'hC9
`define VAR_STATUS 8'hF0
`define VAR_TIME 8'hF1
`define VAR_TYPE 8'hF2
`define ACTION_VALUE 16'h0001
`define FORMAT_VALUE 16'h0002
`define PASSWORD_MAX 16'h03E7
`define PASSWORD_CLOSE 16'hFFFF
`define PASSWORD_RESET 16'h0001
`define MASK8_MAX 16'h00FF
`define MASK10_MAX 16'h03FF
`define ADDR_MIN 16'h0001
`define ADDR_MAX 16'h00FE
`define ADDR_RESET 8'h01
`define RATE_4800 16'h12C0
`define RATE_9600 16'h2580
`define RATE_W_4K8 16'h0030
`define RATE_W_9K6 16'h0060
`define TIME_WRAP 16'hEA5F
`define MS_CYCLES 17'h1_86A0
`define FAULT_TRIP_PATH 8'h04
`define FAULT_ROM 8'h1E
`define FAULT_RAM 8'h32
`define FAULT_EE_BLK1 8'h33
`define FAULT_EE_BLK2 8'h34
`define FAULT_EE_BOTH 8'h35
`define FAULT_EE_CSUM 8'h36
`define FAULT_EE_KEY 8'h38
`define FAULT_REF_LOW_X1 8'hC3
`define FAULT_REF_LOW_X5 8'h83
`define FAULT_REF_LOW_X25 8'h43
`define FAULT_REF_HIGH_X1 8'hCB
`define FAULT_REF_HIGH_X5 8'h8B
`define FAULT_REF_HIGH_X25 8'h4B
`define FAULT_EF_FILTER 8'hFC
`define FAULT_ADC_STALL 8'hFD
`define FAULT_DELAY_CYCLES 8'h10
`define ADC_TIMEOUT_CYCLES 16'hFFFF
`endif

// [core/relay_access_pkg.sv]
// types for the remote parameter access block
`default_nettype none
package relay_access_pkg;
   typedef enum logic [3:0] {
      CMD_NONE = 4'h0,
      CMD_WRITE = 4'h1,
      CMD_READ = 4'h2,
      CMD_EVENT_READ = 4'h4,
      CMD_EVENT_REREAD = 4'h8
   } cmd_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EXEC = 3'b010,
      ST_DONE = 3'b100
   } dev_state_t;
   typedef struct packed {
      logic [15:0] time_ms;
      logic [7:0] channel;
      logic [7:0] code;
   } event_t;
endpackage
`default_nettype wire

// [core/relay_access_if.sv]
// link between remote communicator and relay parameter handler
`timescale 1ns/1ps
`default_nettype none
interface relay_access_if;
   relay_access_pkg::cmd_t cmd;
   logic req;
   logic [7:0] var_id;
   logic [15:0] wdata;
   logic ack;
   logic ok;
   logic [15:0] rdata;
   relay_access_pkg::event_t evt;
   modport device (input cmd, req, var_id, wdata, output ack, ok, rdata, evt);
   modport remote (output cmd, req, var_id, wdata, input ack, ok, rdata, evt);
endinterface
`default_nettype wire

// [core/relay_remote.sv]
// remote communicator end issuing one request at a time
`timescale 1ns/1ps
`default_nettype none
`include "relay_access_map.svh"
module relay_remote (
   input wire logic clk,
   input wire logic rst,
   relay_access_if.remote link,
   input wire logic user_go,
   input wire relay_access_pkg::cmd_t user_cmd,
   input wire logic [7:0] user_var,
   input wire logic [15:0] user_wdata,
   output logic user_busy,
   output logic user_done,
   output logic user_ok,
   output logic [15:0] user_rdata,
   output relay_access_pkg::event_t user_evt
);
   typedef struct packed {
      logic busy;
      logic req;
      relay_access_pkg::cmd_t cmd;
      logic [7:0] var_id;
      logic [15:0] wdata;
      logic done;
      logic ok;
      logic [15:0] rdata;
      relay_access_pkg::event_t evt;
   } rstate_t;
   rstate_t s_q, s_d;
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.req = 1'b0;
      if (!s_q.busy && user_go) begin
         // password open range 1..999 is the caller's duty
         s_d.busy = 1'b1;
         s_d.req = 1'b1;
         s_d.cmd = user_cmd;
         s_d.var_id = user_var;
         s_d.wdata = user_wdata;
      end else if (s_q.busy && link.ack) begin
         s_d.busy = 1'b0;
         s_d.done = 1'b1;
         s_d.ok = link.ok;
         s_d.rdata = link.rdata;
         s_d.evt = link.evt;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign link.req = s_q.req;
   assign link.cmd = s_q.cmd;
   assign link.var_id = s_q.var_id;
   assign link.wdata = s_q.wdata;
   assign user_busy = s_q.busy;
   assign user_done = s_q.done;
   assign user_ok = s_q.ok;
   assign user_rdata = s_q.rdata;
   assign user_evt = s_q.evt;
endmodule
`default_nettype wire

// [tb/relay_access_sva.sv]
// assertion checker for the relay access link
`timescale 1ns/1ps
`default_nettype none
`include "relay_access_map.svh"
module relay_access_sva (
   input wire logic clk,
   input wire logic rst,
   input wire relay_access_pkg::cmd_t cmd,
   input wire logic req,
   input wire logic [7:0] var_id,
   input wire logic [15:0] wdata,
   input wire logic ack,
   input wire logic ok,
   input wire logic [15:0] rdata,
   input wire relay_access_pkg::event_t evt
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic wr;
   logic rd;
   assign wr = req && cmd == relay_access_pkg::CMD_WRITE;
   assign rd = req && cmd == relay_access_pkg::CMD_READ;
   a_ack_after_req: assert property (req |-> !ack ##2 (ack && !req)) else $error("ack not two cycles after request");
   a_ack_has_cause: assert property ($rose(ack) |-> $past(req, 2)) else $error("ack without request");
   a_mask8_range: assert property (wr && var_id inside {[`VAR_MASK_STARTUP:`VAR_MASK_UNDERLOAD]}
      && wdata > `MASK8_MAX |-> ##2 ack && !ok) else $error("wide mask accepted");
   a_mask10_range: assert property (wr && var_id == `VAR_MASK_OUTPUT && wdata > `MASK10_MAX |-> ##2 !ok)
      else $error("output mask too wide accepted");
   a_addr_range: assert property (wr && var_id == `VAR_NODE_ADDRESS && (wdata == 16'h0000 || wdata > `ADDR_MAX)
      |-> ##2 !ok) else $error("bad address accepted");
   a_rate_read: assert property (rd && var_id == `VAR_RATE_SELECT |-> ##2 (rdata == `RATE_4800 || rdata == `RATE_9600))
      else $error("rate read not in baud");
   a_status_code: assert property (rd && var_id == `VAR_STATUS |-> ##2 ok && rdata <= 16'h0003)
      else $error("status code out of set");
   a_time_range: assert property (rd && var_id == `VAR_TIME |-> ##2 rdata <= `TIME_WRAP)
      else $error("time beyond wrap");
   a_pw_change_range: assert property (wr && var_id == `VAR_PASSWORD_CHANGE && wdata > `PASSWORD_MAX
      && wdata != `PASSWORD_CLOSE |-> ##2 !ok) else $error("bad password accepted");
   a_action_accept: assert property (wr && var_id inside {`VAR_SELF_HOLD_RESET, `VAR_RELAY_RECORD_RESET}
      |-> ##2 ok) else $error("action write refused");
   a_format_value: assert property (wr && var_id == `VAR_FACTORY_FORMAT && wdata != `FORMAT_VALUE |-> ##2 !ok)
      else $error("format with wrong value accepted");
   c_addr_write: cover property (wr && var_id == `VAR_NODE_ADDRESS ##2 ok);
   c_reread: cover property (req && cmd == relay_access_pkg::CMD_EVENT_REREAD ##2 ok && evt.code != 8'h00);
   c_status_both: cover property (rd && var_id == `VAR_STATUS ##2 rdata == 16'h0003);
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for both ends of the relay access link
`timescale 1ns/1ps
`default_nettype none
`include "relay_access_map.svh"
module tb_top;
   localparam logic [15:0] type_id = 16'h005a; // arbitrary value
   logic clk = 1'h0, rst = 1'h1, user_go = 1'h0, event_valid = 1'h0, auto_reset_seen = 1'h0;
   logic adc_tick = 1'h0, adc_run = 1'h1, setting_we = 1'h0;
   relay_access_pkg::cmd_t user_cmd = relay_access_pkg::CMD_NONE;
   logic [7:0] user_var = 8'h00, event_channel = 8'h00, event_code = 8'h00;
   logic [15:0] user_wdata = 16'h0000, fault_flags = 16'h0000, setting_val = 16'h0000, setting_max = 16'h0064;
   logic user_busy, user_done, user_ok, relay_release, record_clear, supervision_input;
   logic internal_fault_indicator, supervision_relay, eeprom_format, power_cycle, rate_is_9600;
   logic [15:0] user_rdata, setting_q;
   logic [7:0] fault_code, bus_node_address;
   relay_access_pkg::event_t user_evt;
   int fail_count = 0, compares = 0, n_rel = 0, n_clr = 0, n_sup = 0, n_fmt = 0, n_pwr = 0, i;
   logic [7:0] fault_tab [0:13] = '{8'h04, 8'h1e, 8'h32, 8'h33, 8'h34, 8'h36, 8'h38,
      8'hc3, 8'h83, 8'h43, 8'hcb, 8'h8b, 8'h4b, 8'hfc};
   always #5 clk = ~clk;
   always @(negedge clk) adc_tick <= adc_run && !adc_tick;
   always @(posedge clk) begin
      if (relay_release === 1'h1) n_rel <= n_rel + 1;
      if (record_clear === 1'h1) n_clr <= n_clr + 1;
      if (supervision_input === 1'h1) n_sup <= n_sup + 1;
      if (eeprom_format === 1'h1) n_fmt <= n_fmt + 1;
      if (power_cycle === 1'h1) n_pwr <= n_pwr + 1;
   end
   relay_access_if link ();
   relay_remote u_relay_remote (.clk(clk), .rst(rst), .link(link), .user_go(user_go), .user_cmd(user_cmd),
      .user_var(user_var), .user_wdata(user_wdata), .user_busy(user_busy), .user_done(user_done),
      .user_ok(user_ok), .user_rdata(user_rdata), .user_evt(user_evt));
   relay_device #(.TYPE_CODE(type_id)) u_relay_device (.clk(clk), .rst(rst), .link(link),
      .event_valid(event_valid), .event_channel(event_channel), .event_code(event_code),
      .auto_reset_seen(auto_reset_seen), .fault_flags(fault_flags), .adc_tick(adc_tick),
      .setting_we(setting_we), .setting_val(setting_val), .setting_max(setting_max),
      .relay_release(relay_release), .record_clear(record_clear), .supervision_input(supervision_input),
      .internal_fault_indicator(internal_fault_indicator), .supervision_relay(supervision_relay),
      .eeprom_format(eeprom_format), .power_cycle(power_cycle), .fault_code(fault_code),
      .setting_q(setting_q), .bus_node_address(bus_node_address), .rate_is_9600(rate_is_9600));
   relay_access_sva u_relay_access_sva (.clk(clk), .rst(rst), .cmd(link.cmd), .req(link.req),
      .var_id(link.var_id), .wdata(link.wdata), .ack(link.ack), .ok(link.ok), .rdata(link.rdata), .evt(link.evt));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic op(input relay_access_pkg::cmd_t c, input logic [7:0] v, input logic [15:0] d);
      int n;
      @(negedge clk);
      user_go = 1'h1;
      user_cmd = c;
      user_var = v;
      user_wdata = d;
      @(negedge clk);
      user_go = 1'h0;
      chk(user_busy, 1'h1);
      for (n = 0; n < 20 && user_done !== 1'h1; n++) begin
         @(negedge clk);
      end
      chk(user_done, 1'h1);
      chk(user_busy, 1'h0);
   endtask
   task automatic wr(input logic [7:0] v, input logic [15:0] d, input logic k);
      op(relay_access_pkg::CMD_WRITE, v, d);
      chk(user_ok, k);
   endtask
   task automatic rd(input logic [7:0] v, input logic [15:0] d);
      op(relay_access_pkg::CMD_READ, v, 16'h0000);
      chk(user_ok, 1'h1);
      chk(user_rdata, d);
   endtask
   task automatic ev(input logic [7:0] ch, input logic [7:0] cd);
      @(negedge clk);
      event_valid = 1'h1;
      event_channel = ch;
      event_code = cd;
      @(negedge clk);
      event_valid = 1'h0;
   endtask
   task automatic evq(input relay_access_pkg::cmd_t c, input logic k, input logic [15:0] e);
      op(c, 8'h00, 16'h0000);
      chk(user_ok, k);
      if (k) begin
         chk({user_evt.channel, user_evt.code}, e);
      end
   endtask
   task automatic t_addr_rate;
      chk(bus_node_address, 8'h01);
      rd(`VAR_RATE_SELECT, `RATE_4800);
      wr(`VAR_NODE_ADDRESS, 16'h0000, 1'h0);
      wr(`VAR_NODE_ADDRESS, 16'h00ff, 1'h0);
      wr(`VAR_NODE_ADDRESS, 16'h00fe, 1'h1);
      chk(bus_node_address, 8'hfe);
      wr(`VAR_RATE_SELECT, 16'h0050, 1'h0);
      wr(`VAR_RATE_SELECT, `RATE_W_9K6, 1'h1);
      rd(`VAR_RATE_SELECT, `RATE_9600);
      chk(rate_is_9600, 1'h1);
   endtask
   task automatic t_masks;
      logic [7:0] v;
      for (v = `VAR_MASK_STARTUP; v <= `VAR_MASK_UNDERLOAD; v++) begin
         wr(v, `MASK8_MAX, 1'h1);
         wr(v, 16'h0100, 1'h0);
         rd(v, `MASK8_MAX);
      end
      wr(`VAR_MASK_OUTPUT, `MASK10_MAX, 1'h1);
      wr(`VAR_MASK_OUTPUT, 16'h0400, 1'h0);
      rd(`VAR_MASK_OUTPUT, `MASK10_MAX);
   endtask
   task automatic t_password;
      wr(8'h10, 16'h0005, 1'h0);
      wr(`VAR_FACTORY_FORMAT, `FORMAT_VALUE, 1'h0);
      wr(`VAR_PASSWORD_CHANGE, 16'h0005, 1'h0);
      wr(`VAR_PASSWORD_OPEN, 16'h0002, 1'h0);
      wr(`VAR_PASSWORD_OPEN, `PASSWORD_RESET, 1'h1);
      wr(8'h10, 16'h0032, 1'h1);
      wr(8'h10, 16'h00c8, 1'h0);
      @(negedge clk);
      setting_val = 16'h00c8;
      setting_we = 1'h1;
      @(negedge clk);
      setting_we = 1'h0;
      rd(8'h10, 16'h0032);
      chk(setting_q, 16'h0032);
      wr(`VAR_PASSWORD_CHANGE, 16'h03e8, 1'h0);
      wr(`VAR_PASSWORD_CHANGE, 16'h0007, 1'h1);
      wr(`VAR_PASSWORD_CHANGE, `PASSWORD_CLOSE, 1'h1);
      wr(8'h10, 16'h0014, 1'h0);
      wr(`VAR_PASSWORD_OPEN, 16'h0007, 1'h1);
   endtask
   task automatic t_actions;
      wr(`VAR_SELF_HOLD_RESET, 16'h0002, 1'h1);
      wr(`VAR_SUPERVISION_TEST, 16'h0000, 1'h1);
      chk(n_rel + n_sup, 0);
      wr(`VAR_SELF_HOLD_RESET, `ACTION_VALUE, 1'h1);
      chk(n_rel, 1);
      wr(`VAR_RELAY_RECORD_RESET, `ACTION_VALUE, 1'h1);
      chk({n_rel[15:0], n_clr[15:0]}, 32'h0002_0001);
      wr(`VAR_SUPERVISION_TEST, `ACTION_VALUE, 1'h1);
      chk({n_sup[7:0], 7'h00, internal_fault_indicator}, 16'h0101);
   endtask
   task automatic t_events_status;
      evq(relay_access_pkg::CMD_EVENT_READ, 1'h0, 16'h0000);
      ev(8'h03, 8'h07);
      ev(8'h04, 8'h09);
      evq(relay_access_pkg::CMD_EVENT_READ, 1'h1, 16'h0307);
      repeat (2) evq(relay_access_pkg::CMD_EVENT_REREAD, 1'h1, 16'h0307);
      evq(relay_access_pkg::CMD_EVENT_READ, 1'h1, 16'h0409);
      evq(relay_access_pkg::CMD_EVENT_READ, 1'h0, 16'h0000);
      rd(`VAR_STATUS, 16'h0000);
      repeat (5) ev(8'h01, 8'h01);
      rd(`VAR_STATUS, 16'h0002);
      auto_reset_seen = 1'h1;
      rd(`VAR_STATUS, 16'h0003);
      auto_reset_seen = 1'h0;
      wr(`VAR_STATUS, 16'h0000, 1'h1);
      rd(`VAR_STATUS, 16'h0000);
      wr(`VAR_TIME, `TIME_WRAP, 1'h1);
      op(relay_access_pkg::CMD_READ, `VAR_TIME, 16'h0000);
      chk(user_rdata === `TIME_WRAP || user_rdata === 16'h0000, 1'h1);
      rd(`VAR_TYPE, type_id);
   endtask
   task automatic t_faults;
      // mid-run reset so the fault lamp starts dark again
      @(negedge clk);
      rst = 1'h1;
      repeat (2) @(negedge clk);
      rst = 1'h0;
      chk({internal_fault_indicator, supervision_relay}, 2'h0);
      chk(bus_node_address, 8'h01);
      chk(rate_is_9600, 1'h0);
      wr(`VAR_PASSWORD_OPEN, `PASSWORD_RESET, 1'h1);
      for (i = 0; i < 14; i++) begin
         fault_flags = 16'h0001 << i;
         repeat (20) @(negedge clk);
         chk(fault_code, fault_tab[i]);
         rd(`VAR_FAULT_CODE, {8'h00, fault_tab[i]});
      end
      fault_flags = 16'h0018;
      repeat (20) @(negedge clk);
      chk(fault_code, `FAULT_EE_BOTH);
      chk({internal_fault_indicator, supervision_relay}, 2'h3);
      fault_flags = 16'h0000;
      adc_run = 1'h0;
      repeat (65560) @(negedge clk);
      chk(fault_code, `FAULT_ADC_STALL);
      wr(`VAR_FACTORY_FORMAT, 16'h0003, 1'h0);
      wr(`VAR_FACTORY_FORMAT, `FORMAT_VALUE, 1'h1);
      chk({n_fmt[7:0], n_pwr[7:0]}, 16'h0101);
   endtask
   task automatic stop_test;
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #(900us);
      fail_count++;
      stop_test();
   end
   initial begin
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst = 1'h0;
      t_addr_rate();
      t_masks();
      t_password();
      t_actions();
      t_events_status();
      t_faults();
      stop_test();
   end
endmodule
`default_nettype wire
